// ===== eat_trigger_regs.vh
// Purpose: Offsets, field positions, codes and reset values of the event action trigger
// Assumes: Word offsets on an 8-bit byte address, 32-bit data
// Notes: Included by eat_trigger.v and by the bench
`ifndef EAT_TRIGGER_REGS_VH
`define EAT_TRIGGER_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define EAT_OFS_SLOT_SEL 8'h00
`define EAT_OFS_SLOT_CFG 8'h04
`define EAT_OFS_STATUS 8'h08
`define EAT_OFS_MASK 8'h0C
`define EAT_OFS_HEALTH_THR 8'h10
`define EAT_OFS_ACT_LO 8'h14
`define EAT_OFS_ACT_HI 8'h18

// ----------------------------------------
// Slot configuration fields
// ----------------------------------------
`define EAT_CFG_EN 0
`define EAT_CFG_SRC_LSB 4
`define EAT_CFG_NUM_LSB 8
`define EAT_CFG_DET_LSB 16
`define EAT_CFG_MODE_LSB 20
`define EAT_CFG_W 22
`define EAT_CFG_RST 22'h00_0000
`define EAT_SLOTS 50

// ----------------------------------------
// Event sources
// ----------------------------------------
`define EAT_SRC_SWITCH 4'h0
`define EAT_SRC_REMOTE 4'h1
`define EAT_SRC_RELAY 4'h2
`define EAT_SRC_IO_ALM 4'h3
`define EAT_SRC_MATH_ALM 4'h4
`define EAT_SRC_COMM_ALM 4'h5
`define EAT_SRC_ANY_ALM 4'h6
`define EAT_SRC_TIMER 4'h7
`define EAT_SRC_MATCH 4'h8
`define EAT_SRC_FKEY 4'h9
`define EAT_SRC_STATUS 4'hA
`define EAT_SRC_HEALTH 4'hB

// ----------------------------------------
// Operation modes
// ----------------------------------------
`define EAT_MODE_RISE 2'h0
`define EAT_MODE_FALL 2'h1
`define EAT_MODE_BOTH 2'h2
`define EAT_MODE_OCCUR 2'h3

// ----------------------------------------
// Status and mask bits, reset values
// ----------------------------------------
`define EAT_ST_ACTION 0
`define EAT_ST_REFUSED 1
`define EAT_ST_ANY_ALM 2
`define EAT_ST_HEALTH 3
`define EAT_ST_W 4
`define EAT_ST_RST 4'h0
`define EAT_MASK_RST 4'h0
`define EAT_THR_RST 8'h00
`define EAT_SEL_RST 6'h01

`endif

// ===== eat_trigger.v
// Purpose: Fifty event action slots turning instrument events into action pulses and levels
// Assumes: All event inputs come from logic on MCLK; one register port on MCLK
// Notes: Slot config is reached through a slot select register and a window register
`timescale 1ns/100ps
`default_nettype none
`include "eat_trigger_regs.vh"

module eat_trigger (
   input wire MCLK,
   input wire RST_N,
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [31:0] RDATA,
   input wire [31:0] SWITCH_IN,
   input wire [31:0] REMOTE_IN,
   input wire [31:0] REMOTE_MODE,
   input wire [31:0] REMOTE_PID,
   input wire [31:0] RELAY_IN,
   input wire [127:0] IO_ALARM,
   input wire [31:0] IO_PID,
   input wire [127:0] MATH_ALARM,
   input wire [127:0] COMM_ALARM,
   input wire [7:0] ALARM_COUNT,
   input wire [7:0] HEALTH_SCORE,
   input wire [11:0] TIMER_EXP,
   input wire [11:0] MATCH_EXP,
   input wire [7:0] FKEY,
   input wire [5:0] STAT_IN,
   output reg [49:0] ACTION_PULSE,
   output reg [49:0] ACTION_LEVEL,
   output wire IRQ
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // One-based number into a vector; zero or out of range gives no event
   function pick;
      input [127:0] vec;
      input [5:0] num;
      input [7:0] size;
      reg [7:0] idx;
      begin
         idx = {2'b00, num} - 8'h01;
         if (num == 6'h00 || {2'b00, num} > size) begin
            pick = 1'b0;
         end else begin
            pick = vec[idx[6:0]];
         end
      end
   endfunction

   // Alarm of a numbered channel at one of four levels
   function pick_alarm;
      input [127:0] vec;
      input [5:0] num;
      input [2:0] det;
      reg [7:0] idx;
      begin
         idx = {num - 6'h01, 2'b00} + {6'h00, det[1:0]};
         if (num == 6'h00 || num > 6'd32) begin
            pick_alarm = 1'b0;
         end else begin
            pick_alarm = vec[idx[6:0]];
         end
      end
   endfunction

   // Sources that only exist as occurrences
   function is_occur_src;
      input [3:0] src;
      begin
         is_occur_src = (src == `EAT_SRC_TIMER) || (src == `EAT_SRC_MATCH) ||
                        (src == `EAT_SRC_FKEY) || (src == `EAT_SRC_HEALTH);
      end
   endfunction

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   reg rst_meta;
   reg rst_n;

   always @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   reg [`EAT_CFG_W-1:0] cfg [0:`EAT_SLOTS-1];
   reg [5:0] slot_sel;
   reg [`EAT_ST_W-1:0] status;
   reg [`EAT_ST_W-1:0] mask;
   reg [7:0] health_thr;
   reg [49:0] prev;
   reg any_prev;
   reg health_prev;

   wire [5:0] sel_idx = slot_sel - 6'h01;
   wire wr_sel = WR && ADDR == `EAT_OFS_SLOT_SEL;
   wire wr_cfg = WR && ADDR == `EAT_OFS_SLOT_CFG;
   wire rd_status = RD && ADDR == `EAT_OFS_STATUS;

   // ----------------------------------------
   // Config write check
   // ----------------------------------------
   wire [3:0] w_src = WDATA[`EAT_CFG_SRC_LSB+3:`EAT_CFG_SRC_LSB];
   wire [1:0] w_mode = WDATA[`EAT_CFG_MODE_LSB+1:`EAT_CFG_MODE_LSB];
   reg [1:0] next_mode;
   reg refused;

   always @* begin
      next_mode = w_mode;
      refused = 1'b0;
      if (is_occur_src(w_src)) begin
         // Edge-type requests are forced to occurrence; a level-follow request is refused
         next_mode = `EAT_MODE_OCCUR;
         refused = (w_mode == `EAT_MODE_BOTH);
      end else if (w_mode == `EAT_MODE_OCCUR) begin
         // Level sources have no occurrence mode; fall back to rising
         next_mode = `EAT_MODE_RISE;
         refused = 1'b1;
      end
   end

   // ----------------------------------------
   // Stored form of a config write
   // ----------------------------------------
   reg [`EAT_CFG_W-1:0] next_cfg;

   always @* begin
      // Reserved bits read back as zero whatever software wrote
      next_cfg = `EAT_CFG_RST;
      next_cfg[`EAT_CFG_EN] = WDATA[`EAT_CFG_EN];
      next_cfg[`EAT_CFG_SRC_LSB+3:`EAT_CFG_SRC_LSB] = w_src;
      next_cfg[`EAT_CFG_NUM_LSB+5:`EAT_CFG_NUM_LSB] = WDATA[`EAT_CFG_NUM_LSB+5:`EAT_CFG_NUM_LSB];
      next_cfg[`EAT_CFG_DET_LSB+2:`EAT_CFG_DET_LSB] = WDATA[`EAT_CFG_DET_LSB+2:`EAT_CFG_DET_LSB];
      next_cfg[`EAT_CFG_MODE_LSB+1:`EAT_CFG_MODE_LSB] = next_mode;
   end

   integer i;

   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         slot_sel <= `EAT_SEL_RST;
         for (i = 0; i < `EAT_SLOTS; i = i + 1) begin
            cfg[i] <= `EAT_CFG_RST;
         end
      end else begin
         // Out-of-range slot numbers are ignored so the window always hits a slot
         if (wr_sel && WDATA[5:0] != 6'h00 && WDATA[5:0] <= 6'd50) begin
            slot_sel <= WDATA[5:0];
         end
         if (wr_cfg) begin
            cfg[sel_idx] <= next_cfg;
         end
      end
   end

   // ----------------------------------------
   // Event levels
   // ----------------------------------------
   reg [49:0] lvl;
   reg [49:0] occur;
   reg [49:0] en;
   reg [49:0] mode_fall;
   reg [49:0] mode_both;
   reg [3:0] src;
   reg [5:0] num;
   reg [2:0] det;
   wire any_alarm = ALARM_COUNT != 8'h00;
   wire health_low = HEALTH_SCORE[7] ||
                     ($signed(HEALTH_SCORE) < $signed(health_thr));

   always @* begin : eval_levels
      integer i;
      i = 0;
      src = 4'h0;
      num = 6'h00;
      det = 3'h0;
      for (i = 0; i < `EAT_SLOTS; i = i + 1) begin
         src = cfg[i][`EAT_CFG_SRC_LSB+3:`EAT_CFG_SRC_LSB];
         num = cfg[i][`EAT_CFG_NUM_LSB+5:`EAT_CFG_NUM_LSB];
         det = cfg[i][`EAT_CFG_DET_LSB+2:`EAT_CFG_DET_LSB];
         en[i] = cfg[i][`EAT_CFG_EN];
         mode_fall[i] = cfg[i][`EAT_CFG_MODE_LSB+1:`EAT_CFG_MODE_LSB] == `EAT_MODE_FALL;
         mode_both[i] = cfg[i][`EAT_CFG_MODE_LSB+1:`EAT_CFG_MODE_LSB] == `EAT_MODE_BOTH;
         occur[i] = cfg[i][`EAT_CFG_MODE_LSB+1:`EAT_CFG_MODE_LSB] == `EAT_MODE_OCCUR;
         case (src)
            `EAT_SRC_SWITCH: begin
               lvl[i] = pick({96'h0, SWITCH_IN}, num, 8'd32);
            end
            `EAT_SRC_REMOTE: begin
               // Only inputs set as remote control, never a PID module input
               lvl[i] = pick({96'h0, REMOTE_IN & REMOTE_MODE & ~REMOTE_PID}, num,
                             8'd32);
            end
            `EAT_SRC_RELAY: begin
               lvl[i] = pick({96'h0, RELAY_IN}, num, 8'd32);
            end
            `EAT_SRC_IO_ALM: begin
               // Alarm inputs carry active alarms regardless of logging
               lvl[i] = pick_alarm(IO_ALARM, num, det) &&
                        !pick({96'h0, IO_PID}, num, 8'd32);
            end
            `EAT_SRC_MATH_ALM: begin
               lvl[i] = pick_alarm(MATH_ALARM, num, det);
            end
            `EAT_SRC_COMM_ALM: begin
               lvl[i] = pick_alarm(COMM_ALARM, num, det);
            end
            `EAT_SRC_ANY_ALM: begin
               lvl[i] = any_alarm;
            end
            `EAT_SRC_TIMER: begin
               lvl[i] = pick({116'h0, TIMER_EXP}, num, 8'd12);
            end
            `EAT_SRC_MATCH: begin
               lvl[i] = pick({116'h0, MATCH_EXP}, num, 8'd12);
            end
            `EAT_SRC_FKEY: begin
               lvl[i] = pick({120'h0, FKEY}, num, 8'd8);
            end
            `EAT_SRC_STATUS: begin
               // Record, compute, lockout, media, measure, comm; others never fire
               lvl[i] = (det < 3'd6) ? STAT_IN[det] : 1'b0;
            end
            `EAT_SRC_HEALTH: begin
               lvl[i] = health_low;
            end
            default: begin
               lvl[i] = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Edge detection and actions
   // ----------------------------------------
   reg [49:0] next_pulse;
   reg [3:0] pick_src;

   always @* begin : eval_pulses
      integer i;
      i = 0;
      pick_src = 4'h0;
      for (i = 0; i < `EAT_SLOTS; i = i + 1) begin
         pick_src = cfg[i][`EAT_CFG_SRC_LSB+3:`EAT_CFG_SRC_LSB];
         if (!en[i] || mode_both[i]) begin
            next_pulse[i] = 1'b0;
         end else if (occur[i]) begin
            // Timer-type inputs are already one-cycle pulses; health is a level
            if (pick_src == `EAT_SRC_HEALTH) begin
               next_pulse[i] = lvl[i] && !prev[i];
            end else begin
               next_pulse[i] = lvl[i];
            end
         end else if (mode_fall[i]) begin
            next_pulse[i] = !lvl[i] && prev[i];
         end else begin
            next_pulse[i] = lvl[i] && !prev[i];
         end
      end
   end

   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         prev <= 50'h0;
         ACTION_PULSE <= 50'h0;
         ACTION_LEVEL <= 50'h0;
         any_prev <= 1'b0;
         health_prev <= 1'b0;
      end else begin
         // History runs even while disabled so enabling never fakes an edge
         prev <= lvl;
         ACTION_PULSE <= next_pulse;
         ACTION_LEVEL <= en & mode_both & lvl;
         any_prev <= any_alarm;
         health_prev <= health_low;
      end
   end

   // ----------------------------------------
   // Status, mask and interrupt
   // ----------------------------------------
   reg [`EAT_ST_W-1:0] st_set;

   always @* begin
      st_set = `EAT_ST_RST;
      st_set[`EAT_ST_ACTION] = |next_pulse;
      st_set[`EAT_ST_REFUSED] = wr_cfg && refused;
      st_set[`EAT_ST_ANY_ALM] = any_alarm && !any_prev;
      st_set[`EAT_ST_HEALTH] = health_low && !health_prev;
   end

   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         status <= `EAT_ST_RST;
         mask <= `EAT_MASK_RST;
         health_thr <= `EAT_THR_RST;
      end else begin
         // Set beats the clear of a read in the same cycle
         status <= (rd_status ? `EAT_ST_RST : status) | st_set;
         if (WR && ADDR == `EAT_OFS_MASK) begin
            mask <= WDATA[`EAT_ST_W-1:0];
         end
         if (WR && ADDR == `EAT_OFS_HEALTH_THR) begin
            health_thr <= WDATA[7:0];
         end
      end
   end

   assign IRQ = |(status & mask);

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   reg [31:0] next_rdata;

   always @* begin
      case (ADDR)
         `EAT_OFS_SLOT_SEL: next_rdata = {26'h0, slot_sel};
         `EAT_OFS_SLOT_CFG: next_rdata = {10'h0, cfg[sel_idx]};
         `EAT_OFS_STATUS: next_rdata = {28'h0, status};
         `EAT_OFS_MASK: next_rdata = {28'h0, mask};
         `EAT_OFS_HEALTH_THR: next_rdata = {24'h0, health_thr};
         `EAT_OFS_ACT_LO: next_rdata = ACTION_LEVEL[31:0];
         `EAT_OFS_ACT_HI: next_rdata = {14'h0, ACTION_LEVEL[49:32]};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 32'h0000_0000;
      end else if (RD) begin
         RDATA <= next_rdata;
      end else begin
         // Data stand only in the cycle after the read
         RDATA <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// ===== eat_trigger_properties.sv
// Purpose: Port-level checks of the event action trigger
// Assumes: One clock, reads answer in the next cycle
// Notes: Bound to the design from the bench
`timescale 1ns/100ps
`default_nettype none
module eat_trigger_properties (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [49:0] ACTION_PULSE,
   input wire logic [49:0] ACTION_LEVEL,
   input wire logic IRQ
);
   // --------------------
   // Checks
   // --------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   rd_idle_zero_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data set outside a read");
   rd_unmapped_a: assert property ($past(RD) && $past(ADDR) > 8'h18 |-> RDATA == 32'h0)
      else $error("unmapped read not zero");
   sel_range_a: assert property ($past(RD) && $past(ADDR) == 8'h00
      |-> RDATA >= 32'h0000_0001 && RDATA <= 32'h0000_0032)
      else $error("slot select out of range");
   quiet_reset_a: assert property ($rose(RST_N)
      |-> (ACTION_PULSE == 50'h0 && ACTION_LEVEL == 50'h0) [*2])
      else $error("action after reset");
   lo_view_a: assert property ($past(RD) && $past(ADDR) == 8'h14
      |-> RDATA == $past(ACTION_LEVEL[31:0]))
      else $error("low level view wrong");
   hi_view_a: assert property ($past(RD) && $past(ADDR) == 8'h18
      |-> RDATA == {14'h0000, $past(ACTION_LEVEL[49:32])})
      else $error("high level view wrong");
   mask_off_a: assert property (WR && ADDR == 8'h0C && WDATA[3:0] == 4'h0 |=> !IRQ)
      else $error("interrupt with mask clear");
   occ_mode_a: assert property ($past(RD) && $past(ADDR) == 8'h04
      && RDATA[7:4] inside {4'h7, 4'h8, 4'h9, 4'hB} |-> RDATA[21:20] == 2'h3)
      else $error("occurrence source not in occurrence mode");
   edge_mode_a: assert property ($past(RD) && $past(ADDR) == 8'h04
      && RDATA[7:4] inside {[4'h0:4'h6], 4'hA} |-> RDATA[21:20] != 2'h3)
      else $error("edge source in occurrence mode");
   excl_out_a: assert property ((ACTION_PULSE & ACTION_LEVEL) == 50'h0)
      else $error("pulse and level on one slot");
   cover property (|ACTION_PULSE);
   cover property (|ACTION_LEVEL);
   cover property ($fell(IRQ));
endmodule
`default_nettype wire

// ===== eat_src_model.sv
// Purpose: Instrument source model feeding the trigger
// Assumes: Sources change right after the trigger clock edge
// Notes: Levels are set by the bench, timer timeouts come as pulses
`timescale 1ns/100ps
`default_nettype none
module eat_src_model (
   input wire logic clk,
   output logic [31:0] sw,
   output logic [31:0] rin,
   output logic [31:0] rmode,
   output logic [31:0] rpid,
   output logic [31:0] relay,
   output logic [127:0] io,
   output logic [31:0] iopid,
   output logic [127:0] math,
   output logic [127:0] comm,
   output logic [7:0] acnt,
   output logic [7:0] score,
   output logic [11:0] tmr,
   output logic [11:0] match,
   output logic [7:0] fkey,
   output logic [5:0] stat
);
   // Score starts healthy so that no event is pending at enable
   initial begin
      {sw, rin, rmode, rpid, relay, io, iopid, math, comm} = 576'h0;
      {acnt, tmr, match, fkey, stat} = 46'h0;
      score = 8'h14;
   end
   // Timeout of timer n, held for len cycles
   task automatic tmr_burst(input logic [3:0] n, input int len);
      repeat (len) @(posedge clk) tmr <= 12'h001 << (n - 4'h1);
      @(posedge clk) tmr <= 12'h000;
   endtask
endmodule
`default_nettype wire

// ===== eat_trigger_bench.sv
// Purpose: Self-checking bench of the event action trigger
// Assumes: Slots 1 to 12 each watch one source
// Notes: Events are stepped one at a time so each pulse is attributable, except one last step that changes five sources together
`timescale 1ns/100ps
`default_nettype none
`include "eat_trigger_regs.vh"
bind eat_trigger eat_trigger_properties i_props (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ACTION_PULSE(ACTION_PULSE),
   .ACTION_LEVEL(ACTION_LEVEL), .IRQ(IRQ));
module eat_trigger_bench;
   logic MCLK, RST_N, WR, RD;
   logic [7:0] ADDR;
   logic [31:0] WDATA;
   wire logic [31:0] RDATA, sw, rin, rmode, rpid, relay, iopid;
   wire logic [49:0] ACTION_PULSE, ACTION_LEVEL;
   wire logic IRQ;
   wire logic [127:0] io, math, comm;
   wire logic [7:0] acnt, score, fkey;
   wire logic [11:0] tmr, match;
   wire logic [5:0] stat;
   int err_total, tests_run;
   eat_trigger i_dut (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .SWITCH_IN(sw), .REMOTE_IN(rin), .REMOTE_MODE(rmode),
      .REMOTE_PID(rpid), .RELAY_IN(relay), .IO_ALARM(io), .IO_PID(iopid),
      .MATH_ALARM(math), .COMM_ALARM(comm), .ALARM_COUNT(acnt), .HEALTH_SCORE(score),
      .TIMER_EXP(tmr), .MATCH_EXP(match), .FKEY(fkey), .STAT_IN(stat),
      .ACTION_PULSE(ACTION_PULSE), .ACTION_LEVEL(ACTION_LEVEL), .IRQ(IRQ));
   eat_src_model i_src (.clk(MCLK), .sw(sw), .rin(rin), .rmode(rmode), .rpid(rpid),
      .relay(relay), .io(io), .iopid(iopid), .math(math), .comm(comm), .acnt(acnt),
      .score(score), .tmr(tmr), .match(match), .fkey(fkey), .stat(stat));
   // --------------------
   // Access tasks
   // --------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'b0;
      #1 chk(nm, exp, RDATA);
   endtask
   function automatic logic [31:0] cfg(input logic [3:0] src, input logic [5:0] num,
      input logic [2:0] det, input logic [1:0] md, input logic en);
      cfg = {10'h000, md, 1'b0, det, 2'h0, num, src, 3'h0, en};
   endfunction
   task automatic put(input logic [5:0] s, input logic [31:0] c);
      wr(`EAT_OFS_SLOT_SEL, {26'h0, s});
      wr(`EAT_OFS_SLOT_CFG, c);
   endtask
   // Slots 1 to 12 after the next edge
   task automatic ev(input logic [11:0] p, input logic [11:0] l);
      @(posedge MCLK);
      #1 chk("pulse", {20'h0, p}, ACTION_PULSE[31:0]);
      chk("pulse_hi", 32'h0000_0000, {14'h0, ACTION_PULSE[49:32]});
      chk("level", {20'h0, l}, ACTION_LEVEL[31:0]);
   endtask
   task automatic final_report;
      if (err_total == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // --------------------
   // Sequence
   // --------------------
   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end
   initial begin
      #20000;
      err_total++;
      final_report;
   end
   initial begin
      {WR, RD, RST_N} = 3'b000;
      ADDR = 8'h00;
      WDATA = 32'h0000_0000;
      err_total = 0;
      tests_run = 0;
      repeat (5) @(posedge MCLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      rdc(`EAT_OFS_SLOT_SEL, 32'h0000_0001, "sel");
      rdc(`EAT_OFS_SLOT_CFG, 32'h0000_0000, "cfg");
      rdc(`EAT_OFS_MASK, 32'h0000_0000, "mask");
      rdc(8'h1C, 32'h0000_0000, "unmapped");
      wr(`EAT_OFS_SLOT_SEL, 32'h0000_0000);
      rdc(`EAT_OFS_SLOT_SEL, 32'h0000_0001, "sel");
      wr(`EAT_OFS_SLOT_SEL, 32'h0000_0033);
      rdc(`EAT_OFS_SLOT_SEL, 32'h0000_0001, "sel");
      wr(`EAT_OFS_SLOT_SEL, 32'h0000_0032);
      rdc(`EAT_OFS_SLOT_SEL, 32'h0000_0032, "sel");
      wr(`EAT_OFS_HEALTH_THR, 32'h0000_000A);
      put(6'd1, cfg(`EAT_SRC_SWITCH, 6'd1, 3'h7, `EAT_MODE_RISE, 1'b1));
      put(6'd2, cfg(`EAT_SRC_SWITCH, 6'd1, 3'h0, `EAT_MODE_FALL, 1'b1));
      put(6'd3, cfg(`EAT_SRC_SWITCH, 6'd1, 3'h0, `EAT_MODE_BOTH, 1'b1));
      put(6'd4, cfg(`EAT_SRC_SWITCH, 6'd1, 3'h0, `EAT_MODE_OCCUR, 1'b0));
      rdc(`EAT_OFS_SLOT_CFG, cfg(4'h0, 6'd1, 3'h0, 2'h0, 1'b0), "cfg4");
      put(6'd5, cfg(`EAT_SRC_TIMER, 6'd2, 3'h0, `EAT_MODE_BOTH, 1'b1));
      rdc(`EAT_OFS_SLOT_CFG, cfg(4'h7, 6'd2, 3'h0, 2'h3, 1'b1), "cfg5");
      put(6'd6, cfg(`EAT_SRC_IO_ALM, 6'd1, 3'h2, `EAT_MODE_RISE, 1'b1));
      put(6'd7, cfg(`EAT_SRC_IO_ALM, 6'd2, 3'h0, `EAT_MODE_RISE, 1'b1));
      put(6'd8, cfg(`EAT_SRC_ANY_ALM, 6'd9, 3'h0, `EAT_MODE_RISE, 1'b1));
      put(6'd9, cfg(`EAT_SRC_STATUS, 6'd7, 3'h3, `EAT_MODE_RISE, 1'b1));
      put(6'd10, cfg(`EAT_SRC_HEALTH, 6'd0, 3'h0, `EAT_MODE_OCCUR, 1'b1));
      put(6'd11, cfg(`EAT_SRC_REMOTE, 6'd1, 3'h0, `EAT_MODE_RISE, 1'b1));
      put(6'd12, cfg(`EAT_SRC_REMOTE, 6'd2, 3'h0, `EAT_MODE_RISE, 1'b1));
      @(posedge MCLK) i_src.sw <= 32'h0000_0001;
      ev(12'h001, 12'h004);
      ev(12'h000, 12'h004);
      @(posedge MCLK) i_src.sw <= 32'h0000_0000;
      ev(12'h002, 12'h000);
      fork
         i_src.tmr_burst(4'h2, 2);
         begin
            @(posedge MCLK);
            ev(12'h010, 12'h000);
            ev(12'h010, 12'h000);
            ev(12'h000, 12'h000);
         end
      join
      @(posedge MCLK) i_src.iopid <= 32'h0000_0002;
      i_src.io <= 128'h14;
      ev(12'h020, 12'h000);
      @(posedge MCLK) i_src.acnt <= 8'h03;
      ev(12'h080, 12'h000);
      @(posedge MCLK) i_src.stat <= 6'h04;
      ev(12'h000, 12'h000);
      @(posedge MCLK) i_src.stat <= 6'h0C;
      ev(12'h100, 12'h000);
      @(posedge MCLK) i_src.score <= 8'h05;
      ev(12'h200, 12'h000);
      @(posedge MCLK) i_src.rmode <= 32'h0000_0003;
      i_src.rpid <= 32'h0000_0002;
      i_src.rin <= 32'h0000_0003;
      ev(12'h400, 12'h000);
      @(posedge MCLK) i_src.sw <= 32'h0000_0001;
      ev(12'h001, 12'h004);
      rdc(`EAT_OFS_ACT_LO, 32'h0000_0004, "act_lo");
      rdc(`EAT_OFS_ACT_HI, 32'h0000_0000, "act_hi");
      chk("irq", 32'h0, {31'h0, IRQ});
      wr(`EAT_OFS_MASK, 32'h0000_000F);
      #1 chk("irq", 32'h1, {31'h0, IRQ});
      rdc(`EAT_OFS_STATUS, 32'h0000_000F, "status");
      chk("irq", 32'h0, {31'h0, IRQ});
      rdc(`EAT_OFS_STATUS, 32'h0000_0000, "status");
      put(6'd4, cfg(`EAT_SRC_FKEY, 6'd8, 3'h0, `EAT_MODE_RISE, 1'b1));
      put(6'd7, cfg(`EAT_SRC_MATH_ALM, 6'd2, 3'h3, `EAT_MODE_FALL, 1'b1));
      put(6'd11, cfg(`EAT_SRC_RELAY, 6'd1, 3'h0, `EAT_MODE_RISE, 1'b1));
      put(6'd12, cfg(`EAT_SRC_COMM_ALM, 6'd32, 3'h3, `EAT_MODE_RISE, 1'b1));
      put(6'd50, cfg(`EAT_SRC_MATCH, 6'd12, 3'h0, `EAT_MODE_RISE, 1'b1));
      rdc(`EAT_OFS_SLOT_CFG, cfg(4'h8, 6'd12, 3'h0, 2'h3, 1'b1), "cfg50");
      @(posedge MCLK) i_src.fkey <= 8'h80;
      i_src.match <= 12'h800;
      i_src.math <= 128'h80;
      i_src.comm <= {1'b1, 127'h0};
      i_src.relay <= 32'h0000_0001;
      @(posedge MCLK) i_src.fkey <= 8'h00;
      i_src.match <= 12'h000;
      i_src.math <= 128'h0;
      #1 chk("pulse", 32'h0000_0C08, ACTION_PULSE[31:0]);
      chk("pulse_hi", 32'h0002_0000, {14'h0, ACTION_PULSE[49:32]});
      ev(12'h040, 12'h004);
      rdc(`EAT_OFS_STATUS, 32'h0000_0001, "status");
      chk("irq", 32'h0, {31'h0, IRQ});
      wr(`EAT_OFS_MASK, 32'h0000_0000);
      final_report;
   end
endmodule
`default_nettype wire
